/* hdl/ufd_engine.sv */
module ufd_engine #(
	parameter int SUSPEND_CYC = ufd_pkg::SUSPEND_CYC,
	parameter int RESUME_CYC  = ufd_pkg::RESUME_CYC
) (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        resetn_in,
	// bus pins
	input  wire logic        dp_in,
	input  wire logic        dm_in,
	output logic             dp_out,
	output logic             dm_out,
	output logic             dp_oe_out,
	output logic             dm_oe_out,
	// configuration
	input  wire logic [6:0]  dev_addr_in,
	input  wire logic [4:0]  ep_enable_in,
	input  wire logic [4:0]  ep_stall_in,
	input  wire logic        wake_req_in,
	// IN buffer loading stream
	input  wire logic        ld_valid_in,
	output logic             ld_ready_out,
	input  wire logic [2:0]  ld_ep_in,
	input  wire logic [7:0]  ld_data_in,
	input  wire logic        ld_last_in,
	// OUT buffer readback
	input  wire logic [2:0]  rd_ep_in,
	input  wire logic [5:0]  rd_idx_in,
	output logic [7:0]       rd_data_out,
	output logic [6:0]       rd_len_out,
	input  wire logic [4:0]  out_release_in,
	// status
	output logic [4:0]       in_armed_out,
	output logic [4:0]       out_full_out,
	output logic             out_done_out,
	output logic             setup_done_out,
	output logic             in_done_out,
	output logic             suspended_out,
	output logic             bus_reset_out
);
	localparam int NE = ufd_pkg::N_EP;
	localparam int NB = ufd_pkg::BUF_BYTES;

	typedef struct packed {
		ufd_pkg::ufd_state_e       st;
		logic [1:0]                dp_sy;
		logic [1:0]                dm_sy;
		logic                      dp_prev;
		logic [7:0]                rx_ph;
		logic                      rx_act;
		logic                      rx_lastj;
		logic [7:0]                rx_sr;
		logic [2:0]                rx_ones;
		logic [2:0]                rx_bits;
		logic [7:0]                rx_byte;
		logic                      rx_err;
		logic [6:0]                pk_cnt;
		logic [3:0]                pk_pid;
		logic [7:0]                pk_b1;
		logic [4:0]                crc5;
		logic [15:0]               crc16;
		logic                      exp_data;
		logic                      ack_pend;
		logic                      tok_setup;
		logic [2:0]                tok_ep;
		logic [8:0]                tmo;
		logic [7:0]                tx_ph;
		logic [6:0]                tx_i;
		logic [2:0]                tx_bit;
		logic [2:0]                tx_ones;
		logic                      tx_lvl;
		logic                      tx_se0;
		logic [15:0]               tx_crc;
		logic [3:0]                tx_pid;
		logic                      tx_data;
		logic [6:0]                tx_len;
		logic [1:0]                tx_eop;
		logic [19:0]               cnt;
		logic [NE-1:0][NB-1:0][7:0] in_buf;
		logic [NE-1:0][NB-1:0][7:0] out_buf;
		logic [NE-1:0][6:0]        in_len;
		logic [NE-1:0][6:0]        out_len;
		logic [NE-1:0][6:0]        fill;
		logic [NE-1:0]             in_armed;
		logic [NE-1:0]             out_full;
		logic [NE-1:0]             tog_rx;
		logic [NE-1:0]             tog_tx;
		logic [19:0]               idle_cnt;
		logic [9:0]                se0_cnt;
		logic                      susp;
		logic                      pin_dp;
		logic                      pin_dm;
		logic                      pin_oe;
		logic [7:0]                rd_data;
		logic [6:0]                rd_len;
		logic                      ev_out;
		logic                      ev_setup;
		logic                      ev_in;
	} ufd_eng_s;

	ufd_eng_s    r;
	ufd_eng_s    n;
	logic        f_vld;
	logic        f_rdy;
	logic [11:0] f_dat;
	logic [2:0]  f_ep;

	// endpoint number within range
	function automatic logic ep_ok(input logic [3:0] e);
		ep_ok = e < 4'(NE);
	endfunction

	// IN loading stream buffered ahead of the endpoint buffers
	ufd_fifo #(
		.WIDTH (ufd_pkg::FIFO_W),
		.DEPTH (ufd_pkg::FIFO_DEPTH)
	) u_ld_fifo (
		.clk_sys_in   (clk_sys_in),
		.resetn_in    (resetn_in),
		.wr_valid_in  (ld_valid_in),
		.wr_ready_out (ld_ready_out),
		.wr_data_in   ({ld_last_in, ld_ep_in, ld_data_in}),
		.rd_valid_out (f_vld),
		.rd_ready_in  (f_rdy),
		.rd_data_out  (f_dat)
	);

	// drain stalls while the target buffer is owned by the engine
	assign f_ep  = f_dat[10:8];
	assign f_rdy = ~ep_ok({1'b0, f_ep}) | ~r.in_armed[f_ep];

	always_comb begin
		logic       j_sym, se0, tick, d, eop, good, start, b;
		logic [7:0] nb, sr, pid_b;
		logic [3:0] tep, hs;
		logic [6:0] plen, total, k;
		j_sym = 1'b0; se0 = 1'b0; tick = 1'b0; d = 1'b0; eop = 1'b0;
		good = 1'b0; start = 1'b0; b = 1'b0; nb = 8'h00; sr = 8'h00; pid_b = 8'h00;
		tep = 4'h0; hs = 4'h0; plen = 7'h00; total = 7'h00; k = 7'h00;
		n = r;
		n.ev_out   = 1'b0;
		n.ev_setup = 1'b0;
		n.ev_in    = 1'b0;
		// two-stage pin synchronisers
		n.dp_sy   = {r.dp_sy[0], dp_in};
		n.dm_sy   = {r.dm_sy[0], dm_in};
		n.dp_prev = r.dp_sy[1];
		j_sym     = r.dp_sy[1] & ~r.dm_sy[1];
		se0       = ~r.dp_sy[1] & ~r.dm_sy[1];
		n.out_full = r.out_full & ~out_release_in;
		// bus reset on long single-ended zero
		n.se0_cnt = se0 ? ((r.se0_cnt == 10'h3ff) ? r.se0_cnt : r.se0_cnt + 10'h001) : 10'h000;
		if (r.se0_cnt >= 10'(ufd_pkg::BUSRST_CYC)) begin
			n.tog_rx = '0;
			n.tog_tx = '0;
			n.in_armed = '0;
			n.out_full = '0;
			n.fill = '0;
			n.exp_data = 1'b0;
			n.ack_pend = 1'b0;
		end
		// suspend after long idle, left on any activity
		if (r.st == ufd_pkg::ST_LISTEN) begin
			if (j_sym) begin
				n.idle_cnt = (r.idle_cnt == 20'(SUSPEND_CYC - 1)) ? r.idle_cnt : r.idle_cnt + 20'h00001;
				n.susp = r.susp | (r.idle_cnt == 20'(SUSPEND_CYC - 1));
			end else begin
				n.idle_cnt = 20'h00000;
				n.susp = 1'b0;
			end
		end
		// handshake timeout keeps IN data armed
		if (r.st == ufd_pkg::ST_LISTEN && (r.exp_data | r.ack_pend) && !r.rx_act) begin
			n.tmo = r.tmo + 9'h001;
			if (r.tmo == 9'(ufd_pkg::TMO_CYC - 1)) begin
				n.exp_data = 1'b0;
				n.ack_pend = 1'b0;
			end
		end else begin
			n.tmo = 9'h000;
		end
		// load stream into IN buffers
		if (f_vld && f_rdy && ep_ok({1'b0, f_ep})) begin
			if (r.fill[f_ep] < 7'(NB)) begin
				n.in_buf[f_ep][r.fill[f_ep][5:0]] = f_dat[7:0];
				n.fill[f_ep] = r.fill[f_ep] + 7'h01;
			end
			if (f_dat[11]) begin
				n.in_len[f_ep]   = n.fill[f_ep];
				n.in_armed[f_ep] = 1'b1;
				n.fill[f_ep]     = 7'h00;
			end
		end
		// receiver: bit clock recovery resyncs on every dp edge
		if (r.st == ufd_pkg::ST_LISTEN) begin
			if (r.dp_sy[1] != r.dp_prev) begin
				n.rx_ph = 8'(ufd_pkg::PH_HALF);
			end else if (r.rx_ph + 8'(ufd_pkg::PH_STEP) >= 8'(ufd_pkg::PH_WRAP)) begin
				n.rx_ph = r.rx_ph + 8'(ufd_pkg::PH_STEP) - 8'(ufd_pkg::PH_WRAP);
				tick = 1'b1;
			end else begin
				n.rx_ph = r.rx_ph + 8'(ufd_pkg::PH_STEP);
			end
		end
		if (tick) begin
			if (se0) begin
				eop = r.rx_act;
				n.rx_act = 1'b0;
				n.rx_sr = 8'hff;
			end else begin
				d = (j_sym == r.rx_lastj);
				n.rx_lastj = j_sym;
				if (!r.rx_act) begin
					sr = {d, r.rx_sr[7:1]};
					n.rx_sr = sr;
					if (sr == ufd_pkg::SYNC_BYTE) begin
						n.rx_act = 1'b1;
						n.rx_ones = 3'h1;
						n.rx_bits = 3'h0;
						n.rx_err = 1'b0;
						n.pk_cnt = 7'h00;
						n.crc5 = 5'h1f;
						n.crc16 = 16'hffff;
					end
				end else if (r.rx_ones == 3'h6) begin
					n.rx_ones = 3'h0;
					n.rx_err = r.rx_err | d;
				end else begin
					nb = {d, r.rx_byte[7:1]};
					n.rx_byte = nb;
					n.rx_ones = d ? r.rx_ones + 3'h1 : 3'h0;
					n.rx_bits = r.rx_bits + 3'h1;
					if (r.pk_cnt != 7'h00) begin
						n.crc5 = ufd_pkg::ufd_crc5(r.crc5, d);
						n.crc16 = ufd_pkg::ufd_crc16(r.crc16, d);
					end
					if (r.rx_bits == 3'h7) begin
						n.pk_cnt = (r.pk_cnt == 7'h7f) ? r.pk_cnt : r.pk_cnt + 7'h01;
						if (r.pk_cnt == 7'h00) begin
							n.pk_pid = nb[3:0];
							n.rx_err = r.rx_err | (nb[7:4] != ~nb[3:0]);
						end
						if (r.pk_cnt == 7'h01) begin
							n.pk_b1 = nb;
						end
						// payload straight into a free OUT buffer
						if (r.exp_data && r.pk_cnt != 7'h00 && r.pk_cnt <= 7'(NB) && !r.out_full[r.tok_ep]
								&& (r.pk_pid == ufd_pkg::PID_DATA0 || r.pk_pid == ufd_pkg::PID_DATA1)) begin
							n.out_buf[r.tok_ep][6'(r.pk_cnt - 7'h01)] = nb;
						end
					end
				end
			end
		end
		// end of packet: decode and answer
		if (eop) begin
			good = !r.rx_err && r.rx_bits == 3'h0;
			tep = {r.rx_byte[2:0], r.pk_b1[7]};
			n.ack_pend = 1'b0;
			n.exp_data = 1'b0;
			if (good && r.pk_cnt == 7'h03 && r.crc5 == ufd_pkg::CRC5_RES && (r.pk_pid == ufd_pkg::PID_IN
					|| r.pk_pid == ufd_pkg::PID_OUT || r.pk_pid == ufd_pkg::PID_SETUP)) begin
				if (r.pk_b1[6:0] == dev_addr_in && ep_ok(tep) && ep_enable_in[tep[2:0]]) begin
					n.tok_ep = tep[2:0];
					n.tok_setup = (r.pk_pid == ufd_pkg::PID_SETUP) && tep == 4'h0;
					if (r.pk_pid == ufd_pkg::PID_IN) begin
						start = 1'b1;
						if (ep_stall_in[tep[2:0]]) begin
							hs = ufd_pkg::PID_STALL;
						end else if (r.in_armed[tep[2:0]]) begin
							hs = r.tog_tx[tep[2:0]] ? ufd_pkg::PID_DATA1 : ufd_pkg::PID_DATA0;
						end else begin
							hs = ufd_pkg::PID_NAK;
						end
					end else if (r.pk_pid == ufd_pkg::PID_OUT || tep == 4'h0) begin
						n.exp_data = 1'b1;
						n.tmo = 9'h000;
					end
				end
			end else if (r.exp_data && (r.pk_pid == ufd_pkg::PID_DATA0 || r.pk_pid == ufd_pkg::PID_DATA1)) begin
				plen = r.pk_cnt - 7'h03;
				if (good && r.crc16 == ufd_pkg::CRC16_RES && r.pk_cnt >= 7'h03
						&& plen <= 7'(NB)) begin
					start = 1'b1;
					if (ep_stall_in[r.tok_ep] && !r.tok_setup) begin
						hs = ufd_pkg::PID_STALL;
					end else if (r.out_full[r.tok_ep]) begin
						hs = ufd_pkg::PID_NAK;
					end else begin
						hs = ufd_pkg::PID_ACK;
						if (r.tok_setup || ((r.pk_pid == ufd_pkg::PID_DATA1) == r.tog_rx[r.tok_ep])) begin
							n.out_full[r.tok_ep] = 1'b1;
							n.out_len[r.tok_ep] = plen;
							n.tog_rx[r.tok_ep] = r.tok_setup | ~r.tog_rx[r.tok_ep];
							if (r.tok_setup) begin
								n.tog_tx[r.tok_ep] = 1'b1;
							end
							n.ev_out = ~r.tok_setup;
							n.ev_setup = r.tok_setup;
						end
					end
				end
			end else if (good && r.ack_pend && r.pk_pid == ufd_pkg::PID_ACK && r.pk_cnt == 7'h01) begin
				n.in_armed[r.tok_ep] = 1'b0;
				n.tog_tx[r.tok_ep] = ~r.tog_tx[r.tok_ep];
				n.ev_in = 1'b1;
			end
		end
		if (start) begin
			n.st = ufd_pkg::ST_GAP;
			n.cnt = 20'h00000;
			n.tx_pid = hs;
			n.tx_data = (hs == ufd_pkg::PID_DATA0 || hs == ufd_pkg::PID_DATA1);
			n.tx_len = r.in_len[n.tok_ep];
		end
		// state machine for turnaround, transmit and resume
		case (r.st)
			ufd_pkg::ST_LISTEN: begin
				if (r.susp && wake_req_in && !start) begin
					n.st = ufd_pkg::ST_WAKE;
					n.cnt = 20'h00000;
					n.tx_lvl = 1'b0;
					n.tx_se0 = 1'b0;
				end
			end
			ufd_pkg::ST_GAP: begin
				n.cnt = r.cnt + 20'h00001;
				if (r.cnt == 20'(ufd_pkg::GAP_CYC - 1)) begin
					n.st = ufd_pkg::ST_SEND;
					n.tx_ph = 8'h00;
					n.tx_i = 7'h00;
					n.tx_bit = 3'h1; // first sync bit goes out with the enable
					n.tx_ones = 3'h0;
					n.tx_lvl = 1'b0;
					n.tx_se0 = 1'b0;
					n.tx_crc = 16'hffff;
					n.tx_eop = 2'h0;
				end
			end
			ufd_pkg::ST_SEND: begin
				total = r.tx_data ? r.tx_len + 7'h04 : 7'h02;
				if (r.tx_ph + 8'(ufd_pkg::PH_STEP) >= 8'(ufd_pkg::PH_WRAP)) begin
					n.tx_ph = r.tx_ph + 8'(ufd_pkg::PH_STEP) - 8'(ufd_pkg::PH_WRAP);
					if (r.tx_ones == 3'h6) begin
						n.tx_lvl = ~r.tx_lvl;
						n.tx_ones = 3'h0;
					end else if (r.tx_i < total) begin
						k = r.tx_i - 7'h02;
						if (r.tx_i == 7'h00) begin
							b = ufd_pkg::SYNC_BYTE[r.tx_bit];
						end else if (r.tx_i == 7'h01) begin
							pid_b = {~r.tx_pid, r.tx_pid};
							b = pid_b[r.tx_bit];
						end else if (k < r.tx_len) begin
							b = r.in_buf[r.tok_ep][k[5:0]][r.tx_bit];
							n.tx_crc = ufd_pkg::ufd_crc16(r.tx_crc, b);
						end else begin
							b = ~r.tx_crc[4'hf - {k[0] ^ r.tx_len[0], r.tx_bit}];
						end
						n.tx_lvl = b ? r.tx_lvl : ~r.tx_lvl;
						n.tx_ones = b ? r.tx_ones + 3'h1 : 3'h0;
						n.tx_bit = r.tx_bit + 3'h1;
						if (r.tx_bit == 3'h7) begin
							n.tx_i = r.tx_i + 7'h01;
						end
					end else begin
						n.tx_eop = r.tx_eop + 2'h1;
						n.tx_se0 = r.tx_eop < 2'h2;
						n.tx_lvl = 1'b1;
						if (r.tx_eop == 2'h3) begin
							n.st = ufd_pkg::ST_LISTEN;
							n.ack_pend = r.tx_data;
							n.tmo = 9'h000;
							n.rx_lastj = 1'b1;
							n.rx_act = 1'b0;
							n.rx_sr = 8'hff;
						end
					end
				end else begin
					n.tx_ph = r.tx_ph + 8'(ufd_pkg::PH_STEP);
				end
			end
			ufd_pkg::ST_WAKE: begin
				n.cnt = r.cnt + 20'h00001;
				if (r.cnt == 20'(RESUME_CYC - 1)) begin
					n.st = ufd_pkg::ST_LISTEN;
					n.susp = 1'b0;
					n.idle_cnt = 20'h00000;
				end
			end
			default: begin
				n.st = ufd_pkg::ST_LISTEN;
			end
		endcase
		// registered pin drive and readback
		n.pin_oe  = (n.st == ufd_pkg::ST_SEND) || (n.st == ufd_pkg::ST_WAKE);
		n.pin_dp  = n.pin_oe & ~n.tx_se0 & n.tx_lvl;
		n.pin_dm  = n.pin_oe & ~n.tx_se0 & ~n.tx_lvl;
		n.rd_data = ep_ok({1'b0, rd_ep_in}) ? r.out_buf[rd_ep_in][rd_idx_in] : 8'h00;
		n.rd_len  = ep_ok({1'b0, rd_ep_in}) ? r.out_len[rd_ep_in] : 7'h00;
	end

	// state register
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			r          <= '0;
			r.st       <= ufd_pkg::ST_LISTEN;
			r.rx_lastj <= 1'b1;
			r.rx_sr    <= 8'hff;
		end else begin
			r <= n;
		end
	end

	// outputs
	assign dp_out         = r.pin_dp;
	assign dm_out         = r.pin_dm;
	assign dp_oe_out      = r.pin_oe;
	assign dm_oe_out      = r.pin_oe;
	assign rd_data_out    = r.rd_data;
	assign rd_len_out     = r.rd_len;
	assign in_armed_out   = r.in_armed;
	assign out_full_out   = r.out_full;
	assign out_done_out   = r.ev_out;
	assign setup_done_out = r.ev_setup;
	assign in_done_out    = r.ev_in;
	assign suspended_out  = r.susp;
	assign bus_reset_out  = r.se0_cnt >= 10'(ufd_pkg::BUSRST_CYC);
endmodule

/* hdl/ufd_fifo.sv */
module ufd_fifo #(
	parameter int WIDTH = ufd_pkg::FIFO_W,
	parameter int DEPTH = ufd_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             resetn_in,
	// fill side
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	input  wire logic [WIDTH-1:0] wr_data_in,
	// drain side
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in,
	output logic [WIDTH-1:0]      rd_data_out
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} ufd_fifo_s;

	ufd_fifo_s r;
	ufd_fifo_s n;
	logic      push;
	logic      pop;

	// honest full and empty
	assign wr_ready_out = r.cnt != (AW + 1)'(DEPTH);
	assign rd_valid_out = r.cnt != '0;
	assign rd_data_out  = r.mem[r.rp];
	assign push         = wr_valid_in & wr_ready_out;
	assign pop          = rd_valid_out & rd_ready_in;

	// pointer and storage update
	always_comb begin
		n = r;
		if (push) begin
			n.mem[r.wp] = wr_data_in;
			n.wp        = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
		end
		if (pop) begin
			n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
		end
		n.cnt = r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	// state register
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule

/* include/ufd_pkg.sv */
// Functional notes
// - full-speed 12 Mbps peripheral, never bus master
// - five endpoints, 64-byte IN and OUT buffers
// - endpoint zero control; one to four bulk/interrupt
// - detect suspend, drive remote wakeup resume
// - engine bit timing derived from system clock
// - NRZI, bit stuffing, CRC, serial/parallel conversion
// - recover bit clock, track drift, detect sync
// - address match steers OUT/IN data to buffers
// - bus address and endpoint enables programmable
// - recognise IN/OUT/SETUP, DATA0/1, ACK/NAK/STALL
// - decode token address, endpoint, check CRC5
// - sender alternates DATA0/DATA1 per good packet
// - per-endpoint receive toggle detects repeated packets
// - check and generate CRC16 on payloads
// - ACK accepted error-free OUT data
// - NAK OUT data when buffer busy
// - STALL for halted endpoint
// - no handshake for corrupted data packets
// - IN data held until matching IN token
// - keep IN buffer when no handshake returns
package ufd_pkg;
	// rates and bit-clock accumulator
	localparam int CLK_HZ      = 200_000_000;
	localparam int BIT_HZ      = 12_000_000;
	localparam int PH_STEP     = BIT_HZ / 1_000_000;
	localparam int PH_WRAP     = CLK_HZ / 1_000_000;
	localparam int PH_HALF     = PH_WRAP / 2;
	// bus timing
	localparam int T_SUSPEND_US = 3000;
	localparam int SUSPEND_CYC  = T_SUSPEND_US * PH_WRAP;
	localparam int T_RESUME_US  = 2000;
	localparam int RESUME_CYC   = T_RESUME_US * PH_WRAP;
	localparam int T_BUSRST_NS  = 2500;
	localparam int BUSRST_CYC   = (T_BUSRST_NS * PH_WRAP + 999) / 1000;
	localparam int T_GAP_BITS   = 2;
	localparam int GAP_CYC      = (T_GAP_BITS * PH_WRAP + PH_STEP - 1) / PH_STEP;
	localparam int T_TMO_BITS   = 18;
	localparam int TMO_CYC      = T_TMO_BITS * PH_WRAP / PH_STEP;
	// endpoints and buffers
	localparam int N_EP       = 5;
	localparam int BUF_BYTES  = 64;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_W     = 12;
	// packet identifiers
	localparam logic [3:0] PID_OUT   = 4'h1;
	localparam logic [3:0] PID_IN    = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hd;
	localparam logic [3:0] PID_DATA0 = 4'h3;
	localparam logic [3:0] PID_DATA1 = 4'hb;
	localparam logic [3:0] PID_ACK   = 4'h2;
	localparam logic [3:0] PID_NAK   = 4'ha;
	localparam logic [3:0] PID_STALL = 4'he;
	// coding constants
	localparam logic [7:0]  SYNC_BYTE  = 8'h80;
	localparam logic [4:0]  CRC5_POLY  = 5'h05;
	localparam logic [4:0]  CRC5_RES   = 5'h0c;
	localparam logic [15:0] CRC16_POLY = 16'h8005;
	localparam logic [15:0] CRC16_RES  = 16'h800d;

	typedef enum logic [3:0] {
		ST_LISTEN = 4'h1,
		ST_GAP    = 4'h2,
		ST_SEND   = 4'h4,
		ST_WAKE   = 4'h8
	} ufd_state_e;

	// one serial crc5 step
	function automatic logic [4:0] ufd_crc5(input logic [4:0] c, input logic d);
		ufd_crc5 = {c[3:0], 1'b0} ^ ((d ^ c[4]) ? CRC5_POLY : 5'h00);
	endfunction

	// one serial crc16 step
	function automatic logic [15:0] ufd_crc16(input logic [15:0] c, input logic d);
		ufd_crc16 = {c[14:0], 1'b0} ^ ((d ^ c[15]) ? CRC16_POLY : 16'h0000);
	endfunction
endpackage

/* verif/ufd_engine_chk.sv */
module ufd_engine_chk (
	// clock and reset
	input wire logic       clk_sys_in,
	input wire logic       resetn_in,
	// bus drive
	input wire logic       dp_out,
	input wire logic       dm_out,
	input wire logic       dp_oe_out,
	input wire logic       dm_oe_out,
	// buffers and events
	input wire logic [2:0] rd_ep_in,
	input wire logic [7:0] rd_data_out,
	input wire logic [6:0] rd_len_out,
	input wire logic [4:0] out_release_in,
	input wire logic [4:0] out_full_out,
	input wire logic       out_done_out,
	input wire logic       setup_done_out,
	input wire logic       in_done_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	a_idle_lines_low: assert property (!dp_oe_out |-> !dp_out && !dm_out)
		else $error("lines driven while released");
	a_oe_pair_same: assert property (dp_oe_out == dm_oe_out)
		else $error("output enables differ");
	a_drive_starts_k: assert property ($rose(dp_oe_out) |-> (!dp_out && dm_out) [*8])
		else $error("drive does not open with K");
	a_out_done_pulse: assert property (out_done_out |=> !out_done_out)
		else $error("out done longer than one cycle");
	a_in_done_pulse: assert property (in_done_out |=> !in_done_out)
		else $error("in done longer than one cycle");
	a_done_sets_full: assert property ((out_done_out || setup_done_out) |-> ##[0:1] out_full_out != 5'h00)
		else $error("accepted data without full buffer");
	a_release_clears: assert property (out_release_in != 5'h00
		|=> (out_full_out & $past(out_release_in)) == 5'h00 || out_done_out || setup_done_out)
		else $error("release left buffer full");
	a_bad_ep_zero: assert property (rd_ep_in > 3'd4 |=> rd_data_out == 8'h00 && rd_len_out == 7'h00)
		else $error("readback of missing endpoint");
endmodule

bind ufd_engine ufd_engine_chk i_chk (.clk_sys_in, .resetn_in, .dp_out, .dm_out, .dp_oe_out, .dm_oe_out,
	.rd_ep_in, .rd_data_out, .rd_len_out, .out_release_in, .out_full_out, .out_done_out, .setup_done_out,
	.in_done_out);

/* verif/ufd_host.sv */
module ufd_host (
	// engine drive
	input  wire logic dp_out,
	input  wire logic dm_out,
	input  wire logic dp_oe_out,
	// wire levels
	output logic      dp_in,
	output logic      dm_in
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam real BT = 1000.0 / 12.0; // one bit time
	logic       h_oe = 0;
	logic       h_dp = 1;
	logic       h_dm = 0;
	logic [7:0] pl[$]; // next data payload
	logic       q[$];
	// engine first, then host, else pull-up idle J
	assign dp_in = dp_oe_out ? dp_out : h_oe ? h_dp : 1'b1;
	assign dm_in = dp_oe_out ? dm_out : h_oe ? h_dm : 1'b0;
	// queue n bits lsb first
	task automatic put(input logic [7:0] v, input int n);
		for (int i = 0; i < n; i++) q.push_back(v[i]);
	endtask
	// gap, sync, stuffed nrzi body, eop
	task automatic tx();
		int   ones;
		logic lv;
		ones = 0;
		lv = 1;
		q.push_front(1'b1);
		repeat (7) q.push_front(1'b0);
		#(2 * BT);
		h_oe = 1;
		foreach (q[i]) begin
			if (!q[i]) lv = ~lv;
			{h_dp, h_dm} = {lv, ~lv};
			#BT;
			ones = q[i] ? ones + 1 : 0;
			if (ones == 6) begin
				lv = ~lv;
				{h_dp, h_dm} = {lv, ~lv};
				#BT;
				ones = 0;
			end
		end
		{h_dp, h_dm} = 2'b00;
		#(2 * BT);
		{h_dp, h_dm} = 2'b10;
		h_oe = 0; // pull-up holds the closing J; early release stays ahead of a fast reply
		q = {};
	endtask
	// handshake; only ACK is ever sent
	task automatic hs(input logic [3:0] p);
		put({~p, p}, 8);
		tx();
	endtask
	// token with crc5
	task automatic tok(input logic [3:0] p, input logic [6:0] a, input logic [3:0] e);
		logic [4:0]  c;
		logic [10:0] f;
		c = 5'h1f;
		f = {e, a};
		put({~p, p}, 8);
		for (int i = 0; i < 11; i++) begin
			q.push_back(f[i]);
			c = {c[3:0], 1'b0} ^ ((f[i] ^ c[4]) ? 5'h05 : 5'h00);
		end
		for (int i = 4; i >= 0; i--) q.push_back(~c[i]);
		tx();
	endtask
	// data packet with crc16, optionally corrupted
	task automatic dat(input logic [3:0] p, input logic bad);
		logic [15:0] c;
		c = 16'hffff;
		put({~p, p}, 8);
		foreach (pl[j]) for (int i = 0; i < 8; i++) begin
			q.push_back(pl[j][i]);
			c = {c[14:0], 1'b0} ^ ((pl[j][i] ^ c[15]) ? 16'h8005 : 16'h0000);
		end
		c[0] ^= bad;
		for (int i = 15; i >= 0; i--) q.push_back(~c[i]);
		tx();
	endtask
	// reply pid byte, zero when the engine stays silent
	task automatic rx(output logic [7:0] pid);
		logic        lv;
		logic [15:0] b;
		lv = 1;
		pid = 8'h00;
		for (int i = 0; i < 150 && !dp_oe_out; i++) #5;
		if (!dp_oe_out) return;
		#(BT / 2);
		for (int i = 0; i < 16; i++) begin
			b[i] = (dp_out == lv);
			lv = dp_out;
			#BT;
		end
		pid = b[15:8];
		while (dp_oe_out) #5;
	endtask
endmodule

/* verif/usb_full_speed_device_engine_test.sv */
module usb_full_speed_device_engine_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] TO = ufd_pkg::PID_OUT, TS = ufd_pkg::PID_SETUP, TI = ufd_pkg::PID_IN;
	localparam logic [3:0] D0 = ufd_pkg::PID_DATA0, D1 = ufd_pkg::PID_DATA1, HA = ufd_pkg::PID_ACK;
	localparam logic [3:0] HN = ufd_pkg::PID_NAK, HS = ufd_pkg::PID_STALL;
	logic        clk_sys_in = 0, resetn_in = 0, wake_req_in = 0, ld_valid_in = 0, ld_last_in = 0;
	logic        dp_in, dm_in, dp_out, dm_out, dp_oe_out, dm_oe_out, ld_ready_out, out_done_out;
	logic        setup_done_out, in_done_out, suspended_out, bus_reset_out;
	logic [6:0]  dev_addr_in = 0, rd_len_out;
	logic [4:0]  ep_enable_in = 5'h0f, ep_stall_in = 5'h08, out_release_in = 0, in_armed_out, out_full_out;
	logic [2:0]  ld_ep_in = 0, rd_ep_in = 0;
	logic [5:0]  rd_idx_in = 0;
	logic [7:0]  ld_data_in = 0, rd_data_out, r;
	logic [31:0] s = 76;
	int          err_total = 0, comparisons = 0, cyc = 0, n_out = 0, n_in = 0;
	bit          rb = 0;

	ufd_engine #(.SUSPEND_CYC(2000), .RESUME_CYC(100)) i_dut (.clk_sys_in, .resetn_in, .dp_in, .dm_in,
		.dp_out, .dm_out, .dp_oe_out, .dm_oe_out, .dev_addr_in, .ep_enable_in, .ep_stall_in, .wake_req_in,
		.ld_valid_in, .ld_ready_out, .ld_ep_in, .ld_data_in, .ld_last_in, .rd_ep_in, .rd_idx_in, .rd_data_out,
		.rd_len_out, .out_release_in, .in_armed_out, .out_full_out, .out_done_out, .setup_done_out,
		.in_done_out, .suspended_out, .bus_reset_out);
	ufd_host i_host (.dp_out, .dm_out, .dp_oe_out, .dp_in, .dm_in);

	// clock
	initial forever #2.5 clk_sys_in = ~clk_sys_in;
	// xorshift source
	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [7:0] pb(input logic [3:0] p);
		return {~p, p};
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic summarize();
		$display("mismatches %0d of %0d compares", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// token, data, reply
	task automatic out(input logic [6:0] a, input logic [3:0] e, t, p, input logic bad, input logic [7:0] x);
		i_host.tok(t, a, e);
		i_host.dat(p, bad);
		i_host.rx(r);
		chk(r, x);
	endtask
	task automatic inx(input logic [3:0] e, input logic [7:0] x);
		i_host.tok(TI, dev_addr_in, e);
		i_host.rx(r);
		chk(r, x);
	endtask
	// n-byte packet into the load stream
	task automatic ld(input logic [2:0] e, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys_in);
			{ld_valid_in, ld_ep_in, ld_last_in} = {1'b1, e, i == n - 1};
			ld_data_in = 8'(rnd());
			while (!ld_ready_out) @(negedge clk_sys_in);
		end
		@(negedge clk_sys_in);
		ld_valid_in = 0;
	endtask
	// cycle watch, event counts, hang limit
	always @(posedge clk_sys_in) begin
		cyc++;
		n_out += out_done_out;
		n_in += in_done_out;
		if (cyc == 60000) begin
			err_total++;
			summarize();
		end
	end
	// random readback address between checks
	always @(negedge clk_sys_in) if (!rb) {rd_ep_in, rd_idx_in} <= 9'(rnd());
	// main sequence
	initial begin
		dev_addr_in = 7'(rnd()) | 7'h01;
		repeat (8) i_host.pl.push_back(8'(rnd()));
		repeat (16) @(negedge clk_sys_in);
		resetn_in = 1;
		repeat (4) @(negedge clk_sys_in);
		out(dev_addr_in, 1, TO, D0, 0, pb(HA));
		chk(8'(n_out), 1);
		chk(out_full_out[1], 1);
		rb = 1;
		@(negedge clk_sys_in);
		{rd_ep_in, rd_idx_in} = {3'd1, 6'd5};
		repeat (2) @(negedge clk_sys_in);
		chk(rd_data_out, i_host.pl[5]);
		chk(rd_len_out, 8);
		rb = 0;
		out(dev_addr_in, 1, TO, D0, 0, pb(HN));
		@(negedge clk_sys_in);
		out_release_in = 5'h02;
		@(negedge clk_sys_in);
		out_release_in = 0;
		out(dev_addr_in, 1, TO, D0, 0, pb(HA));
		chk(out_full_out[1], 0);
		out(dev_addr_in, 1, TO, D1, 1, 8'h00);
		out(dev_addr_in, 1, TO, D1, 0, pb(HA));
		chk(8'(n_out), 2);
		out(dev_addr_in ^ 7'h40, 2, TO, D0, 0, 8'h00);
		out(dev_addr_in, 4, TO, D0, 0, 8'h00);
		out(dev_addr_in, 3, TO, D0, 0, pb(HS));
		out(dev_addr_in, 0, TS, D0, 0, pb(HA));
		chk(setup_done_out | out_full_out[0], 1);
		inx(2, pb(HN));
		ld(2, 3);
		repeat (10) @(negedge clk_sys_in);
		chk(in_armed_out[2], 1);
		{ld_valid_in, ld_last_in} = 2'b11;
		repeat (20) @(negedge clk_sys_in);
		chk(ld_ready_out, 0);
		ld_valid_in = 0;
		inx(2, pb(D0));
		repeat (400) @(negedge clk_sys_in);
		inx(2, pb(D0));
		i_host.hs(HA);
		repeat (20) @(negedge clk_sys_in);
		chk(8'(n_in), 1);
		chk(ld_ready_out, 1);
		inx(2, pb(D1));
		repeat (2100) @(negedge clk_sys_in);
		chk(suspended_out, 1);
		wake_req_in = 1;
		repeat (10) @(negedge clk_sys_in);
		chk({dp_oe_out, dp_out, dm_out}, 3'b101);
		wake_req_in = 0;
		// long single-ended zero from the host resets the bus state
		repeat (120) @(negedge clk_sys_in);
		{i_host.h_oe, i_host.h_dp, i_host.h_dm} = 3'b100;
		repeat (520) @(negedge clk_sys_in);
		chk(bus_reset_out, 1);
		chk(out_full_out, 0);
		i_host.h_oe = 0;
		summarize();
	end
endmodule
